// ### inc/mpo_pkg.sv
/*
  package for the motor pwm output stage: register byte offsets, field
  positions, reset values and mode encodings.
  assumes a 32-bit avalon-mm slave port with byte addresses.
*/
package mpo_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [5:0] OFS_TB_CTRL   = 6'h00; // time_base_control
  localparam logic [5:0] OFS_PERIOD    = 6'h04; // period_value buffer
  localparam logic [5:0] OFS_EVT_CMP   = 6'h08; // event_trigger_compare
  localparam logic [5:0] OFS_OUT_CFG   = 6'h0c; // output_config_register
  localparam logic [5:0] OFS_UPD_CFG   = 6'h10; // update_config_register
  localparam logic [5:0] OFS_FLT_CTRL  = 6'h14; // fault_input_control
  localparam logic [5:0] OFS_OVD_CTRL  = 6'h18; // manual_override_control
  localparam logic [5:0] OFS_DUTY1     = 6'h1c; // duty buffers 1..3
  localparam logic [5:0] OFS_DUTY2     = 6'h20;
  localparam logic [5:0] OFS_DUTY3     = 6'h24;
  localparam logic [5:0] OFS_STATUS    = 6'h28; // flags and counter
  // ==========================================================
  // field positions
  localparam int TB_EN_BIT    = 15; // time_base_enable_bit
  localparam int EVT_DIR_BIT  = 15; // event_direction_bit
  localparam int FLT_MODE_BIT = 7;  // fault_mode_bit, 1 = cycle-by-cycle
  localparam int OVERRIDE_SYNC_BIT_BIT    = 1;  // override_sync_bit
  localparam int UPDATE_LOCKOUT_BIT_BIT     = 0;  // update_lockout_bit
  localparam int OPS_LSB      = 8;  // event_postscale_field <11:8>
  localparam int OVD_SEL_LSB  = 8;  // override_select_bits <13:8>
  localparam int FLT_OV_LSB   = 8;  // fault state bits <13:8>
  localparam int PEN_L_LSB    = 0;  // low-side pin enables <2:0>
  localparam int PEN_H_LSB    = 4;  // high-side pin enables <6:4>
  localparam int PMOD_LSB     = 8;  // independent-mode bits <10:8>
  localparam int STS_FLT_BIT  = 0;  // fault flag, write one to clear
  localparam int STS_ACT_BIT  = 1;  // fault override active
  localparam int STS_CNT_LSB  = 16; // counter readback
  // ==========================================================
  // reset values and encodings
  localparam logic [14:0] PERIOD_RST  = 15'h7fff;
  localparam logic [15:0] OVD_RST     = 16'h3f00;
  localparam logic [15:0] PEN_ALL     = 16'h0077;
  localparam logic [1:0]  MODE_FREE   = 2'h0;
  localparam logic [1:0]  MODE_SINGLE = 2'h2;
  localparam int          DEAD_CYC    = 4; // dead counter load; a complementary pair stays off for this plus one clock cycles

  typedef struct packed {
    logic [2:0] h;
    logic [2:0] l;
  } mpo_pins_t;
endpackage : mpo_pkg

// ### core/mpo_output_ctrl.sv
/*
  motor pwm output stage: minimal time base, duty compare, override,
  dead time, fault handling, polarity, pin enables and adc event trigger.
  assumes all inputs synchronous to clk; fuses stable from reset release.
*/
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
// Behaviour
// - mode field value 10 selects single-pulse, edge-aligned only.
// - single-pulse: pins go active when enable set, inactive on duty match.
// - single-pulse period match clears counter, outputs, enable, raises interrupt.
// - six override-select bits in upper half replace duty signal per pin.
// - six override value bits in lower half give overridden pin state.
// - complementary mode: low side active by override is complement of high.
// - dead time still inserted between pair outputs while overridden.
// - with sync bit, override applies at zero, also period match if centered.
// - after reset pins inactive if pin fuse 0, tri-stated if 1.
// - high and low side polarities come from the two polarity fuses.
// - each pin has its own enable; disabled pin is released as gpio.
// - fault affects a pair only when its fault enable is set.
// - fault state bits give forced level, active or inactive by polarity.
// - latched fault ends at boundary after input high and flag cleared.
// - cycle-by-cycle fault ends at next boundary after input goes high.
// - one fault mode bit selects latched or cycle-by-cycle handling.
// - update lockout blocks duty and period buffer transfers.
// - adc trigger when counter equals event compare value.
// - up/down modes: direction bit picks up or down phase.
// - events pass a postscaler from 1:1 to 1:16, four-bit field.
// - postscaler count cleared on compare write and on reset.
// - in sleep a low fault input raises a wake interrupt.
// - edge-aligned: active at counter zero, inactive on duty match.
module mpo_output_ctrl #(
  parameter int DEAD = mpo_pkg::DEAD_CYC
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [5:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic             high_polarity_fuse,
  input  wire logic             low_polarity_fuse,
  input  wire logic             reset_pin_control_fuse,
  input  wire logic             fault_input,
  input  wire logic             sleep_mode,
  output mpo_pkg::mpo_pins_t    pwm_out,
  output mpo_pkg::mpo_pins_t    pwm_oe_n,
  output logic                  period_irq,
  output logic                  fault_irq,
  output logic                  wake_irq,
  output logic                  adc_trigger
);
  import mpo_pkg::*;

  // ==========================================================
  // registers
  logic [15:0] tb_ctrl_ff, evt_cmp_ff, out_cfg_ff, upd_cfg_ff;
  logic [15:0] flt_ctrl_ff, ovd_ctrl_ff, ovd_act_ff;
  logic [14:0] per_buf_ff, per_act_ff, cnt_ff;
  logic [15:0] duty_buf_ff [3];
  logic [15:0] duty_act_ff [3];
  logic        dn_ff, flt_flag_ff, flt_act_ff, init_ff, flt_prev_ff;
  logic [3:0]  ops_cnt_ff;
  logic [31:0] avs_readdata_ff;
  logic        avs_wait_ff;
  logic [2:0]  hi_last_ff;
  logic [7:0]  dt_cnt_ff [3];
  mpo_pins_t   pwm_out_ff, pwm_oe_n_ff;
  logic        period_irq_ff, fault_irq_ff, wake_irq_ff, adc_trig_ff;

  logic        wr, tb_en, single, updown, at_zero, at_per, boundary;
  logic        clr_flag, set_flag;
  logic [1:0]  mode;

  // ==========================================================
  // avalon slave: one wait cycle, then the request is taken
  assign wr  = avs_write & ~avs_wait_ff;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    return a[5:2] == ofs[5:2];
  endfunction : hit

  // waitrequest drops for exactly one edge per request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_wait_ff <= 1'b1;
    end else begin
      avs_wait_ff <= ~((avs_read | avs_write) & avs_wait_ff);
    end
  end

  // read data captured at the edge that drops waitrequest
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata_ff <= 32'h0;
    end else if (avs_read & avs_wait_ff) begin
      avs_readdata_ff <= 32'h0; // unmapped reads return zero
      if (hit(avs_address, OFS_TB_CTRL))  avs_readdata_ff[15:0] <= tb_ctrl_ff;
      if (hit(avs_address, OFS_PERIOD))   avs_readdata_ff[14:0] <= per_buf_ff;
      if (hit(avs_address, OFS_EVT_CMP))  avs_readdata_ff[15:0] <= evt_cmp_ff;
      if (hit(avs_address, OFS_OUT_CFG))  avs_readdata_ff[15:0] <= out_cfg_ff;
      if (hit(avs_address, OFS_UPD_CFG))  avs_readdata_ff[15:0] <= upd_cfg_ff;
      if (hit(avs_address, OFS_FLT_CTRL)) avs_readdata_ff[15:0] <= flt_ctrl_ff;
      if (hit(avs_address, OFS_OVD_CTRL)) avs_readdata_ff[15:0] <= ovd_ctrl_ff;
      if (hit(avs_address, OFS_DUTY1))    avs_readdata_ff[15:0] <= duty_buf_ff[0];
      if (hit(avs_address, OFS_DUTY2))    avs_readdata_ff[15:0] <= duty_buf_ff[1];
      if (hit(avs_address, OFS_DUTY3))    avs_readdata_ff[15:0] <= duty_buf_ff[2];
      if (hit(avs_address, OFS_STATUS)) begin
        avs_readdata_ff[STS_FLT_BIT] <= flt_flag_ff;
        avs_readdata_ff[STS_ACT_BIT] <= flt_act_ff;
        avs_readdata_ff[STS_CNT_LSB +: 15] <= cnt_ff;
      end
    end
  end

  // plain control registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_buf_ff  <= PERIOD_RST;
      evt_cmp_ff  <= 16'h0;
      upd_cfg_ff  <= 16'h0;
      flt_ctrl_ff <= 16'h0;
      ovd_ctrl_ff <= OVD_RST;
      for (int i = 0; i < 3; i++) duty_buf_ff[i] <= 16'h0;
    end else if (wr) begin
      if (hit(avs_address, OFS_PERIOD))   per_buf_ff  <= avs_writedata[14:0];
      if (hit(avs_address, OFS_EVT_CMP))  evt_cmp_ff  <= avs_writedata[15:0];
      if (hit(avs_address, OFS_UPD_CFG))  upd_cfg_ff  <= avs_writedata[15:0];
      if (hit(avs_address, OFS_FLT_CTRL)) flt_ctrl_ff <= avs_writedata[15:0];
      if (hit(avs_address, OFS_OVD_CTRL)) ovd_ctrl_ff <= avs_writedata[15:0];
      if (hit(avs_address, OFS_DUTY1))    duty_buf_ff[0] <= avs_writedata[15:0];
      if (hit(avs_address, OFS_DUTY2))    duty_buf_ff[1] <= avs_writedata[15:0];
      if (hit(avs_address, OFS_DUTY3))    duty_buf_ff[2] <= avs_writedata[15:0];
    end
  end

  // pin enables: strap taken one edge after release, never in reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_ff    <= 1'b0;
      out_cfg_ff <= 16'h0;
    end else if (!init_ff) begin
      init_ff    <= 1'b1;
      out_cfg_ff <= reset_pin_control_fuse ? 16'h0 : PEN_ALL;
    end else if (wr && hit(avs_address, OFS_OUT_CFG)) begin
      out_cfg_ff <= avs_writedata[15:0];
    end
  end

  // ==========================================================
  // time base
  assign tb_en    = tb_ctrl_ff[TB_EN_BIT];
  assign mode     = tb_ctrl_ff[1:0];
  assign single   = (mode == MODE_SINGLE);
  assign updown   = mode[0];
  assign at_zero  = (cnt_ff == 15'h0);
  assign at_per   = (cnt_ff == per_act_ff);
  // cycle boundary, plus the half-cycle in centered modes
  assign boundary = tb_en & (at_zero | (updown & at_per));

  // enable bit: software sets it, single-pulse end clears it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tb_ctrl_ff <= 16'h0;
    end else if (tb_en && single && at_per) begin
      tb_ctrl_ff[TB_EN_BIT] <= 1'b0;
    end else if (wr && hit(avs_address, OFS_TB_CTRL)) begin
      tb_ctrl_ff <= avs_writedata[15:0];
    end
  end

  // counter and direction; centered modes turn at period and zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= 15'h0;
      dn_ff  <= 1'b0;
    end else if (!tb_en) begin
      cnt_ff <= 15'h0;
      dn_ff  <= 1'b0;
    end else if (updown) begin
      if (!dn_ff && at_per) begin
        dn_ff  <= 1'b1;
        cnt_ff <= cnt_ff - 15'h1;
      end else if (dn_ff && at_zero) begin
        dn_ff  <= 1'b0;
        cnt_ff <= cnt_ff + 15'h1;
      end else begin
        cnt_ff <= dn_ff ? cnt_ff - 15'h1 : cnt_ff + 15'h1;
      end
    end else if (at_per) begin
      cnt_ff <= 15'h0;
    end else begin
      cnt_ff <= cnt_ff + 15'h1;
    end
  end

  // period interrupt pulse on every period match reached while not counting down
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      period_irq_ff <= 1'b0;
    end else begin
      period_irq_ff <= tb_en & at_per & ~(updown & dn_ff);
    end
  end

  // buffer transfer at reload points or while stopped, unless locked out
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_act_ff <= PERIOD_RST;
      for (int i = 0; i < 3; i++) duty_act_ff[i] <= 16'h0;
    end else if (!upd_cfg_ff[UPDATE_LOCKOUT_BIT_BIT] &&
                 (!tb_en || (updown ? at_zero : at_per))) begin
      per_act_ff <= per_buf_ff;
      for (int i = 0; i < 3; i++) duty_act_ff[i] <= duty_buf_ff[i];
    end
  end

  // ==========================================================
  // override latch: immediate, or at time-base sync points
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovd_act_ff <= OVD_RST;
    end else if (!upd_cfg_ff[OVERRIDE_SYNC_BIT_BIT] || !tb_en || boundary) begin
      ovd_act_ff <= ovd_ctrl_ff;
    end
  end

  // ==========================================================
  // fault handling; a new fault beats a same-cycle flag clear
  assign clr_flag = wr & hit(avs_address, OFS_STATUS) & avs_writedata[STS_FLT_BIT];
  assign set_flag = flt_prev_ff & ~fault_input; // falling edge only

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flt_flag_ff <= 1'b0;
    end else if (set_flag) begin
      flt_flag_ff <= 1'b1;
    end else if (clr_flag) begin
      flt_flag_ff <= 1'b0;
    end
  end

  // override state: entered on low input, left at a boundary
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flt_act_ff <= 1'b0;
    end else if (!fault_input) begin
      flt_act_ff <= 1'b1;
    end else if (flt_ctrl_ff[FLT_MODE_BIT]) begin
      if (boundary || !tb_en) flt_act_ff <= 1'b0;
    end else if ((boundary || !tb_en) && !flt_flag_ff && !clr_flag) begin
      flt_act_ff <= 1'b0;
    end
  end

  // interrupt and wake outputs; line history idles high, no false edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_irq_ff <= 1'b0;
      wake_irq_ff  <= 1'b0;
      flt_prev_ff  <= 1'b1;
    end else begin
      fault_irq_ff <= flt_flag_ff;
      flt_prev_ff  <= fault_input;
      wake_irq_ff  <= sleep_mode & ~fault_input;
    end
  end

  // ==========================================================
  // special event trigger with postscaler
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ops_cnt_ff  <= 4'h0;
      adc_trig_ff <= 1'b0;
    end else begin
      adc_trig_ff <= 1'b0;
      if (wr && hit(avs_address, OFS_EVT_CMP)) begin
        ops_cnt_ff <= 4'h0;
      end else if (tb_en && cnt_ff == evt_cmp_ff[14:0] &&
                   (!updown || dn_ff == evt_cmp_ff[EVT_DIR_BIT])) begin
        if (ops_cnt_ff == upd_cfg_ff[OPS_LSB +: 4]) begin
          ops_cnt_ff  <= 4'h0;
          adc_trig_ff <= 1'b1;
        end else begin
          ops_cnt_ff <= ops_cnt_ff + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // output path: compare, override, dead time, fault, polarity
  logic [2:0] cmp, hi_want, lo_want, h_lvl, l_lvl, h_pin, l_pin;
  logic [5:0] sel, val, fov;

  // select/value bit order: 3h,3l,2h,2l,1h,1l from msb down
  assign sel = ovd_act_ff[OVD_SEL_LSB +: 6];
  assign val = ovd_act_ff[5:0];
  assign fov = flt_ctrl_ff[FLT_OV_LSB +: 6];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // active from zero until duty match; stopped base means inactive
      cmp[i] = tb_en & ({cnt_ff, 1'b0} < duty_act_ff[i]);
      hi_want[i] = sel[2*i+1] ? val[2*i+1] : cmp[i];
      if (out_cfg_ff[PMOD_LSB+i]) begin
        lo_want[i] = sel[2*i] ? val[2*i] : cmp[i];
      end else begin
        // overridden-active low side mirrors the high side
        lo_want[i] = sel[2*i] ? (val[2*i] & ~hi_want[i]) : ~hi_want[i];
      end
    end
  end

  // dead time per pair, applied after override as well
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_last_ff <= 3'h0;
      for (int i = 0; i < 3; i++) dt_cnt_ff[i] <= 8'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        hi_last_ff[i] <= hi_want[i];
        if (hi_want[i] != hi_last_ff[i]) begin
          dt_cnt_ff[i] <= 8'(DEAD);
        end else if (dt_cnt_ff[i] != 8'h0) begin
          dt_cnt_ff[i] <= dt_cnt_ff[i] - 8'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // complementary pairs both off while the dead counter runs
      if (!out_cfg_ff[PMOD_LSB+i] &&
          (dt_cnt_ff[i] != 8'h0 || hi_want[i] != hi_last_ff[i])) begin
        h_lvl[i] = 1'b0;
        l_lvl[i] = 1'b0;
      end else begin
        h_lvl[i] = hi_want[i];
        l_lvl[i] = lo_want[i];
      end
      // fault wins over manual override on an enabled pair
      if (flt_act_ff && flt_ctrl_ff[i]) begin
        h_lvl[i] = fov[2*i+1];
        l_lvl[i] = fov[2*i];
      end
      h_pin[i] = h_lvl[i] ^ ~high_polarity_fuse;
      l_pin[i] = l_lvl[i] ^ ~low_polarity_fuse;
    end
  end

  // registered pins; disabled pins released to the port logic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_out_ff  <= '0;
      pwm_oe_n_ff <= '1;
    end else begin
      pwm_out_ff.h  <= h_pin;
      pwm_out_ff.l  <= l_pin;
      pwm_oe_n_ff.h <= ~out_cfg_ff[PEN_H_LSB +: 3];
      pwm_oe_n_ff.l <= ~out_cfg_ff[PEN_L_LSB +: 3];
    end
  end

  assign avs_readdata    = avs_readdata_ff;
  assign avs_waitrequest = avs_wait_ff;
  assign pwm_out         = pwm_out_ff;
  assign pwm_oe_n        = pwm_oe_n_ff;
  assign period_irq      = period_irq_ff;
  assign fault_irq       = fault_irq_ff;
  assign wake_irq        = wake_irq_ff;
  assign adc_trigger     = adc_trig_ff;
endmodule : mpo_output_ctrl

// ### testbench/mpo_output_ctrl_properties.sv
/*
  concurrent checks on the ports of the motor pwm output stage.
  assumes one clock domain, clk, and the async active-high sys_rst.
*/
// ==========================================================
// port checker
module mpo_output_ctrl_properties #(
  parameter int DEAD = 4
) (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic [5:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  input wire logic               high_polarity_fuse,
  input wire logic               low_polarity_fuse,
  input wire logic               reset_pin_control_fuse,
  input wire logic               fault_input,
  input wire logic               sleep_mode,
  input wire mpo_pkg::mpo_pins_t pwm_out,
  input wire mpo_pkg::mpo_pins_t pwm_oe_n,
  input wire logic               period_irq,
  input wire logic               fault_irq,
  input wire logic               wake_irq,
  input wire logic               adc_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  import mpo_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // bus request steps: a new request, then waitrequest low for a single cycle
  sequence bus_req_s;
    $rose(avs_read || avs_write);
  endsequence
  sequence bus_ack_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  req_answer_a: assert property (bus_req_s |=> bus_ack_s)
    else $error("waitrequest did not drop for one cycle after a request");
  wait_idle_a: assert property ((!avs_read && !avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  wake_set_a: assert property ((sleep_mode && !fault_input) |=> wake_irq)
    else $error("no wake interrupt for a low fault input in sleep");
  wake_clear_a: assert property ((!sleep_mode || fault_input) |=> !wake_irq)
    else $error("wake interrupt without cause");
  fault_flag_a: assert property ($fell(fault_input) |-> ##2 fault_irq)
    else $error("fault flag not set by a low fault input");
  period_pulse_a: assert property (period_irq |=> !period_irq)
    else $error("period interrupt longer than one cycle");
  adc_pulse_a: assert property (adc_trigger |=> !adc_trigger)
    else $error("adc trigger longer than one cycle");
  oe_release_a: assert property (($past(sys_rst) && reset_pin_control_fuse) |->
    (pwm_oe_n == 6'h3f) [*2])
    else $error("pins driven after reset with release fuse set");
  oe_drive_a: assert property (($past(sys_rst) && !reset_pin_control_fuse) |->
    ##2 (pwm_oe_n == 6'h00))
    else $error("pins not driven after reset with release fuse clear");
endmodule : mpo_output_ctrl_properties

bind mpo_output_ctrl mpo_output_ctrl_properties #(.DEAD(DEAD)) mpo_output_ctrl_properties_i (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .high_polarity_fuse(high_polarity_fuse),
  .low_polarity_fuse(low_polarity_fuse), .reset_pin_control_fuse(reset_pin_control_fuse),
  .fault_input(fault_input), .sleep_mode(sleep_mode), .pwm_out(pwm_out),
  .pwm_oe_n(pwm_oe_n), .period_irq(period_irq), .fault_irq(fault_irq),
  .wake_irq(wake_irq), .adc_trigger(adc_trigger));

// ### testbench/mpo_power_stage.sv
/*
  power stage and fault source beside the pwm pins.
  assumes fault_cmd is changed by the bench just after a clock edge.
*/
// ==========================================================
// pin and fault model
module mpo_power_stage (
  input  wire logic               clk,
  input  wire logic               fault_cmd,
  input  wire mpo_pkg::mpo_pins_t pwm_out,
  input  wire mpo_pkg::mpo_pins_t pwm_oe_n,
  output logic                    fault_input,
  output mpo_pkg::mpo_pins_t      pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  import mpo_pkg::*;
  mpo_pins_t last_ff = '0;

  // released pins toggle every cycle, no pull on these lines
  assign pin_level = mpo_pins_t'((pwm_out & ~pwm_oe_n) | (~last_ff & pwm_oe_n));
  always_ff @(posedge clk) begin
    last_ff <= pin_level;
  end
  // fault line is active low
  assign fault_input = ~fault_cmd;
endmodule : mpo_power_stage

// ### testbench/tb_motor_pwm_output_control.sv
/*
  self-checking bench for the motor pwm output stage.
  assumes the avalon map and latencies of the designer's hand-over.
*/
// ==========================================================
// bench top
module tb_motor_pwm_output_control;
  timeunit 1ns;
  timeprecision 1ps;
  import mpo_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        high_polarity_fuse = 1'b1;
  logic        low_polarity_fuse = 1'b0;
  logic        reset_pin_control_fuse = 1'b1;
  logic        fault_cmd = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        fault_input;
  mpo_pins_t   pwm_out;
  mpo_pins_t   pwm_oe_n;
  mpo_pins_t   pin_level;
  logic        period_irq;
  logic        fault_irq;
  logic        wake_irq;
  logic        adc_trigger;
  int          num_errors = 0;
  int          cmp_count = 0;

  always #2.5 clk = ~clk;

  mpo_output_ctrl mpo_output_ctrl_i (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .high_polarity_fuse(high_polarity_fuse),
    .low_polarity_fuse(low_polarity_fuse), .reset_pin_control_fuse(reset_pin_control_fuse),
    .fault_input(fault_input), .sleep_mode(sleep_mode), .pwm_out(pwm_out),
    .pwm_oe_n(pwm_oe_n), .period_irq(period_irq), .fault_irq(fault_irq),
    .wake_irq(wake_irq), .adc_trigger(adc_trigger));
  mpo_power_stage mpo_power_stage_i (
    .clk(clk), .fault_cmd(fault_cmd), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n),
    .fault_input(fault_input), .pin_level(pin_level));

  // ==========================================================
  // shared helpers
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cycles(int n);
    repeat (n) @(posedge clk);
  endtask : cycles
  // request held until waitrequest is sampled low; bounded wait
  task automatic bus(logic wr, logic [5:0] a, logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    if (n >= 100) num_errors++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(logic [5:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(string what, logic [5:0] a, logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask : rd
  task automatic pins(string what, logic [5:0] exp);
    cycles(4);
    check(what, {26'h0, exp}, {26'h0, pin_level});
  endtask : pins
  task automatic do_reset(logic fuse);
    sys_rst <= 1'b1;
    reset_pin_control_fuse <= fuse;
    cycles(3);
    sys_rst <= 1'b0;
    cycles(3);
  endtask : do_reset

  // ==========================================================
  // scenarios
  task automatic t_reset;
    do_reset(1'b1);
    check("oe_n fuse1", 32'h3f, {26'h0, pwm_oe_n});
    rd("out_cfg fuse1", OFS_OUT_CFG, 32'h0000);
    rd("period reset", OFS_PERIOD, 32'h7fff);
    rd("override reset", OFS_OVD_CTRL, 32'h3f00);
    wr(6'h2c, 32'hffff);
    rd("unmapped", 6'h2c, 32'h0);
    do_reset(1'b0); // second reset in mid-run, pins driven inactive
    check("oe_n fuse0", 32'h00, {26'h0, pwm_oe_n});
    pins("inactive levels", 6'h07);
    rd("out_cfg fuse0", OFS_OUT_CFG, 32'h0077);
  endtask : t_reset
  // independent pairs so override values reach the pins unchanged, then complementary pairs for mirror and dead time
  task automatic t_override;
    wr(OFS_OUT_CFG, 32'h0777);
    wr(OFS_OVD_CTRL, 32'h3f15);
    pins("low sides active", 6'h00);
    wr(OFS_OVD_CTRL, 32'h3f2a);
    pins("high sides active", 6'h3f);
    wr(OFS_OUT_CFG, 32'h0770);
    cycles(3);
    check("low pins released", 32'h07, {26'h0, pwm_oe_n});
    wr(OFS_OUT_CFG, 32'h0077);
    wr(OFS_OVD_CTRL, 32'h3f3f);
    pins("low mirrors high", 6'h3f);
    wr(OFS_OVD_CTRL, 32'h3f15);
    pins("dead time gap", 6'h07);
    wr(OFS_OVD_CTRL, 32'h3f2a);
    wr(OFS_OUT_CFG, 32'h0777);
  endtask : t_override
  task automatic t_fault;
    wr(OFS_FLT_CTRL, 32'h1500);
    fault_cmd <= 1'b1;
    pins("fault ignored", 6'h3f);
    check("fault flag", 32'h1, {31'h0, fault_irq});
    sleep_mode <= 1'b1;
    cycles(2);
    check("wake irq", 32'h1, {31'h0, wake_irq});
    sleep_mode <= 1'b0;
    fault_cmd <= 1'b0;
    wr(OFS_STATUS, 32'h1);
    wr(OFS_FLT_CTRL, 32'h1587);
    fault_cmd <= 1'b1;
    pins("cycle fault state", 6'h00);
    fault_cmd <= 1'b0;
    pins("cycle fault end", 6'h3f);
    wr(OFS_STATUS, 32'h1);
    wr(OFS_FLT_CTRL, 32'h1507);
    fault_cmd <= 1'b1;
    pins("latched fault state", 6'h00);
    fault_cmd <= 1'b0;
    pins("latched fault held", 6'h00);
    wr(OFS_STATUS, 32'h1);
    pins("latched fault end", 6'h3f);
    fault_cmd <= 1'b1;
    wr(OFS_STATUS, 32'h1);
    fault_cmd <= 1'b0;
    pins("early clear", 6'h3f);
    wr(OFS_FLT_CTRL, 32'h0);
  endtask : t_fault
  // one single pulse; width counted on the first high-side pin
  task automatic pulse(string what);
    int n;
    int irq;
    n = 0;
    irq = 0;
    wr(OFS_TB_CTRL, 32'h8002);
    repeat (40) begin
      @(posedge clk);
      if (pin_level.h[0] === 1'b1) n++;
      if (period_irq === 1'b1) irq++;
    end
    check(what, 32'h8, n);
    check("one period irq", 32'h1, irq);
    check("pin idle after", 32'h0, {31'h0, pin_level.h[0]});
    rd("enable cleared", OFS_TB_CTRL, 32'h0002);
  endtask : pulse
  task automatic t_single;
    wr(OFS_OVD_CTRL, 32'h0000);
    wr(OFS_DUTY1, 32'h0010);
    wr(OFS_PERIOD, 32'h0014);
    pulse("pulse width");
    wr(OFS_UPD_CFG, 32'h0001);
    wr(OFS_DUTY1, 32'h0028);
    pulse("width under lockout");
    wr(OFS_UPD_CFG, 32'h0000);
  endtask : t_single
  // ten-cycle period, 1:3 postscale: six matches give two triggers
  task automatic t_adc;
    int n;
    n = 0;
    wr(OFS_PERIOD, 32'h0009);
    wr(OFS_UPD_CFG, 32'h0202);
    wr(OFS_EVT_CMP, 32'h0003);
    wr(OFS_TB_CTRL, 32'h8000);
    repeat (60) begin
      @(posedge clk);
      if (adc_trigger === 1'b1) n++;
    end
    check("adc triggers", 32'h2, n);
    wr(OFS_OVD_CTRL, 32'h3f2a);
    pins("sync override", 6'h0e);
    wr(OFS_TB_CTRL, 32'h0);
  endtask : t_adc

  task automatic stop_test;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    t_reset();
    t_override();
    t_fault();
    t_single();
    t_adc();
    stop_test();
  end
  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule : tb_motor_pwm_output_control
